// ### ffi_pkg.sv
// Shared constants and types for the free-fall interrupt output block
package ffi_pkg;
    localparam int ACC_W = 16;
    localparam int QT_W = 24;

    // Register offsets
    localparam logic [7:0] OFS_STATUS = 8'h11;
    localparam logic [7:0] OFS_MAP_A = 8'h2b;
    localparam logic [7:0] OFS_MAP_B = 8'h2d;
    localparam logic [7:0] OFS_QUIET_CTL = 8'h37;
    localparam logic [7:0] OFS_AXIS_EN = 8'h38;
    localparam logic [7:0] OFS_LEVEL_HI = 8'h3e;
    localparam logic [7:0] OFS_LEVEL_LO = 8'h3f;
    localparam logic [7:0] OFS_TIME_HI = 8'h40;
    localparam logic [7:0] OFS_TIME_MID = 8'h41;
    localparam logic [7:0] OFS_TIME_LO = 8'h42;
    localparam logic [7:0] OFS_PIN_A_CFG = 8'h5d;
    localparam logic [7:0] OFS_PIN_B_CFG = 8'h5e;

    // Field positions
    localparam int QUIET_EV_BIT = 6;
    localparam int QUIET_EN_BIT = 2;
    localparam int POL_BIT = 7;
    localparam int AXIS_N = 3;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Timing
    localparam int CLK_MHZ = 125;
    localparam int SETTLE_US = 2000;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

    typedef struct packed {
        logic signed [ACC_W-1:0] x;
        logic signed [ACC_W-1:0] y;
        logic signed [ACC_W-1:0] z;
    } ffi_sample_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ffi_reg_req_t;
endpackage

// ### ffi_top.sv
// Free-fall detection and interrupt pin output logic
`timescale 1ns/1ps

// Overview of operation
// - Free fall flagged only when every enabled axis stays below threshold for set time.
// - Comparison is absolute: magnitude against threshold, no reference sample.
// - Threshold registers hold output codes: g times scale factor of the range.
// - Three time registers hold the minimum below-threshold duration.
// - Time register counts output data samples: seconds times data rate.
// - Free fall sets the quiet status flag and drives any mapped pin.
// - Output is unsettled for a period after entering measurement mode.
// - Each source maps to pin A, pin B, both or neither; all run together.
// - A pin shows the OR of all events mapped to it.
// - A pin with nothing mapped to it is high impedance.
// - Both pins are high impedance after reset.
// - Pins are active high by default.
// - Polarity bit 7 of each pin configuration register makes the pin active low.
// - An undriven pin keeps its last logic level.
module ffi_top #(
    parameter int SETTLE_CYCLES = ffi_pkg::SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ffi_pkg::ffi_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic measure_mode,
    input wire logic sample_valid,
    input wire ffi_pkg::ffi_sample_t sample,
    input wire logic [7:0] other_events,
    output logic settled,
    output logic quiet_flag,
    output logic irq_out_a_o,
    output logic irq_out_a_oe,
    output logic irq_out_b_o,
    output logic irq_out_b_oe
);
    import ffi_pkg::*;

    // Refused at elaboration; a zero window would make settled unreachable
    if (SETTLE_CYCLES < 1) begin : g_settle_chk
        $error("SETTLE_CYCLES must be at least one");
    end

    localparam int SC_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SC_W-1:0] SETTLE_END = SC_W'(SETTLE_CYCLES);

    // Magnitude is one bit wider so the most negative code cannot wrap
    function automatic logic [ACC_W:0] mag(input logic signed [ACC_W-1:0] v);
        logic [ACC_W:0] ext;
        ext = {v[ACC_W-1], v};
        mag = v[ACC_W-1] ? (~ext + 1'b1) : ext;
    endfunction

    logic [7:0] map_a_reg;
    logic [7:0] map_b_reg;
    logic [7:0] quiet_ctl_reg;
    logic [7:0] axis_en_reg;
    logic [7:0] level_hi_reg;
    logic [7:0] level_lo_reg;
    logic [7:0] time_hi_reg;
    logic [7:0] time_mid_reg;
    logic [7:0] time_lo_reg;
    logic [7:0] pin_a_cfg_reg;
    logic [7:0] pin_b_cfg_reg;
    logic quiet_flag_reg;
    logic [QT_W-1:0] quiet_cnt_reg;
    logic [QT_W-1:0] quiet_cnt_next;
    logic [SC_W-1:0] settle_cnt_reg;
    logic settled_reg;
    logic measure_prev_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic pin_a_o_reg;
    logic pin_a_oe_reg;
    logic pin_b_o_reg;
    logic pin_b_oe_reg;

    logic [ACC_W:0] level;
    logic [QT_W-1:0] quiet_time;
    logic [AXIS_N-1:0] axis_below;
    logic all_below;
    logic quiet_hit;
    logic status_rd;
    logic [7:0] status_vec;
    logic act_a;
    logic act_b;

    assign level = {1'b0, level_hi_reg, level_lo_reg};
    assign quiet_time = {time_hi_reg, time_mid_reg, time_lo_reg};

    // Absolute compare of each axis; disabled axes never block detection
    always_comb begin
        axis_below[0] = !axis_en_reg[0] || (mag(sample.x) < level);
        axis_below[1] = !axis_en_reg[1] || (mag(sample.y) < level);
        axis_below[2] = !axis_en_reg[2] || (mag(sample.z) < level);
        all_below = &axis_below;
    end

    // Register writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            map_a_reg <= RST_BYTE;
            map_b_reg <= RST_BYTE;
            quiet_ctl_reg <= RST_BYTE;
            axis_en_reg <= RST_BYTE;
            level_hi_reg <= RST_BYTE;
            level_lo_reg <= RST_BYTE;
            time_hi_reg <= RST_BYTE;
            time_mid_reg <= RST_BYTE;
            time_lo_reg <= RST_BYTE;
            pin_a_cfg_reg <= RST_BYTE;
            pin_b_cfg_reg <= RST_BYTE;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                OFS_MAP_A: map_a_reg <= reg_req.wdata;
                OFS_MAP_B: map_b_reg <= reg_req.wdata;
                OFS_QUIET_CTL: quiet_ctl_reg <= reg_req.wdata;
                OFS_AXIS_EN: axis_en_reg <= reg_req.wdata;
                OFS_LEVEL_HI: level_hi_reg <= reg_req.wdata;
                OFS_LEVEL_LO: level_lo_reg <= reg_req.wdata;
                OFS_TIME_HI: time_hi_reg <= reg_req.wdata;
                OFS_TIME_MID: time_mid_reg <= reg_req.wdata;
                OFS_TIME_LO: time_lo_reg <= reg_req.wdata;
                OFS_PIN_A_CFG: pin_a_cfg_reg <= reg_req.wdata;
                OFS_PIN_B_CFG: pin_b_cfg_reg <= reg_req.wdata;
                default: begin
                end
            endcase
        end
    end

    // Settling window restarts on each entry to measurement mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            measure_prev_reg <= 1'b0;
            settle_cnt_reg <= '0;
            settled_reg <= 1'b0;
        end else begin
            measure_prev_reg <= measure_mode;
            if (!measure_mode || !measure_prev_reg) begin
                settle_cnt_reg <= '0;
                settled_reg <= 1'b0;
            end else if (settle_cnt_reg != SETTLE_END) begin
                settle_cnt_reg <= settle_cnt_reg + 1'b1;
                settled_reg <= (settle_cnt_reg + 1'b1) == SETTLE_END;
            end
        end
    end

    // Detection is suspended while data is unsettled or the function is off
    always_comb begin
        quiet_cnt_next = quiet_cnt_reg;
        quiet_hit = 1'b0;
        if (!quiet_ctl_reg[QUIET_EN_BIT] || !settled_reg) begin
            quiet_cnt_next = '0;
        end else if (sample_valid) begin
            if (!all_below) begin
                quiet_cnt_next = '0;
            end else if (quiet_cnt_reg + 1'b1 >= quiet_time) begin
                quiet_hit = 1'b1;
                quiet_cnt_next = quiet_time;
            end else begin
                quiet_cnt_next = quiet_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_cnt_reg <= '0;
        end else begin
            quiet_cnt_reg <= quiet_cnt_next;
        end
    end

    assign status_rd = reg_req.rd && (reg_req.addr == OFS_STATUS);

    // Sticky flag; a new hit in the clearing cycle wins over the read clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_flag_reg <= 1'b0;
        end else if (quiet_hit) begin
            quiet_flag_reg <= 1'b1;
        end else if (status_rd) begin
            quiet_flag_reg <= 1'b0;
        end
    end

    always_comb begin
        status_vec = other_events;
        status_vec[QUIET_EV_BIT] = quiet_flag_reg;
    end

    // Register reads answer one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= RD_UNMAPPED;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_req.rd;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    OFS_STATUS: rdata_reg <= status_vec;
                    OFS_MAP_A: rdata_reg <= map_a_reg;
                    OFS_MAP_B: rdata_reg <= map_b_reg;
                    OFS_QUIET_CTL: rdata_reg <= quiet_ctl_reg;
                    OFS_AXIS_EN: rdata_reg <= axis_en_reg;
                    OFS_LEVEL_HI: rdata_reg <= level_hi_reg;
                    OFS_LEVEL_LO: rdata_reg <= level_lo_reg;
                    OFS_TIME_HI: rdata_reg <= time_hi_reg;
                    OFS_TIME_MID: rdata_reg <= time_mid_reg;
                    OFS_TIME_LO: rdata_reg <= time_lo_reg;
                    OFS_PIN_A_CFG: rdata_reg <= pin_a_cfg_reg;
                    OFS_PIN_B_CFG: rdata_reg <= pin_b_cfg_reg;
                    default: rdata_reg <= RD_UNMAPPED;
                endcase
            end
        end
    end

    assign act_a = |(status_vec & map_a_reg);
    assign act_b = |(status_vec & map_b_reg);

    // Pin drivers; level stays put while released so the keeper holds it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_a_o_reg <= 1'b0;
            pin_a_oe_reg <= 1'b0;
        end else begin
            pin_a_oe_reg <= |map_a_reg;
            if (|map_a_reg) begin
                pin_a_o_reg <= act_a ^ pin_a_cfg_reg[POL_BIT];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_b_o_reg <= 1'b0;
            pin_b_oe_reg <= 1'b0;
        end else begin
            pin_b_oe_reg <= |map_b_reg;
            if (|map_b_reg) begin
                pin_b_o_reg <= act_b ^ pin_b_cfg_reg[POL_BIT];
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign settled = settled_reg;
    assign quiet_flag = quiet_flag_reg;
    assign irq_out_a_o = pin_a_o_reg;
    assign irq_out_a_oe = pin_a_oe_reg;
    assign irq_out_b_o = pin_b_o_reg;
    assign irq_out_b_oe = pin_b_oe_reg;
endmodule

// ### ffi_host_model.sv
// Host interrupt input model seeing both pins through their keepers
`timescale 1ns/1ps
module ffi_host_model (
    input wire logic pin_a_o,
    input wire logic pin_a_oe,
    input wire logic pin_b_o,
    input wire logic pin_b_oe,
    output logic level_a,
    output logic level_b
);
    // Keeper holds the last driven level; low at power-up by choice
    initial begin
        level_a = 1'b0;
        level_b = 1'b0;
    end
    always @* begin
        if (pin_a_oe) level_a = pin_a_o;
        if (pin_b_oe) level_b = pin_b_o;
    end
endmodule

// ### ffi_top_properties.sv
// Concurrent checks on the ports of the free-fall interrupt block
`timescale 1ns/1ps
module ffi_top_properties
    import ffi_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire ffi_pkg::ffi_reg_req_t reg_req,
    input wire logic reg_rvalid,
    input wire logic measure_mode,
    input wire logic sample_valid,
    input wire logic settled,
    input wire logic quiet_flag,
    input wire logic irq_out_a_o,
    input wire logic irq_out_a_oe,
    input wire logic irq_out_b_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] mode_cnt;
    // Counter avoids a long repetition for the settle window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) mode_cnt <= 32'h0000_0000;
        else if (!measure_mode) mode_cnt <= 32'h0000_0000;
        else mode_cnt <= mode_cnt + 32'h0000_0001;
    end
    property p_hiz; $rose(rst_n) |-> !irq_out_a_oe && !irq_out_b_oe; endproperty
    a_hiz: assert property (p_hiz) else $error("pin driven after reset");
    property p_rd; reg_rvalid == $past(reg_req.rd); endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
    property p_smp; $rose(quiet_flag) |-> $past(sample_valid); endproperty
    a_smp: assert property (p_smp) else $error("flag without sample");
    property p_stl; $rose(quiet_flag) |-> $past(settled); endproperty
    a_stl: assert property (p_stl) else $error("flag while unsettled");
    property p_win; $rose(settled) |-> mode_cnt >= 32'(SETTLE_CYCLES); endproperty
    a_win: assert property (p_win) else $error("settled too early");
    property p_clr;
        $fell(quiet_flag) |-> $past(reg_req.rd && reg_req.addr == OFS_STATUS);
    endproperty
    a_clr: assert property (p_clr) else $error("flag lost without read");
    property p_keep; !irq_out_a_oe && $past(!irq_out_a_oe) |-> $stable(irq_out_a_o); endproperty
    a_keep: assert property (p_keep) else $error("undriven pin moved");
    property p_map; $changed(irq_out_a_oe) |-> $past(reg_req.wr, 2); endproperty
    a_map: assert property (p_map) else $error("enable moved without write");
    c_flag: cover property ($rose(quiet_flag));
    c_pin: cover property (irq_out_a_oe && irq_out_a_o);
    c_stl: cover property ($rose(settled));
endmodule

bind ffi_top ffi_top_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) ffi_top_properties_i (
    .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rvalid(reg_rvalid),
    .measure_mode(measure_mode), .sample_valid(sample_valid), .settled(settled),
    .quiet_flag(quiet_flag), .irq_out_a_o(irq_out_a_o), .irq_out_a_oe(irq_out_a_oe),
    .irq_out_b_oe(irq_out_b_oe));

// ### ffi_top_tb.sv
// Self-checking bench for the free-fall interrupt block
`timescale 1ns/1ps
module ffi_top_tb;
    import ffi_pkg::*;
    logic clk, rst_n, measure_mode, sample_valid, reg_rvalid, settled, quiet_flag;
    logic irq_out_a_o, irq_out_a_oe, irq_out_b_o, irq_out_b_oe, level_a, level_b;
    logic [7:0] reg_rdata, other_events;
    ffi_reg_req_t reg_req;
    ffi_sample_t sample;
    int n_errors = 0;
    int checks = 0;
    ffi_top #(.SETTLE_CYCLES(8)) ffi_top_i (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .measure_mode(measure_mode),
        .sample_valid(sample_valid), .sample(sample), .other_events(other_events),
        .settled(settled), .quiet_flag(quiet_flag), .irq_out_a_o(irq_out_a_o),
        .irq_out_a_oe(irq_out_a_oe), .irq_out_b_o(irq_out_b_o), .irq_out_b_oe(irq_out_b_oe));
    ffi_host_model ffi_host_model_i (.pin_a_o(irq_out_a_o), .pin_a_oe(irq_out_a_oe),
        .pin_b_o(irq_out_b_o), .pin_b_oe(irq_out_b_oe), .level_a(level_a), .level_b(level_b));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cyc;
        @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc;
        reg_req = '{1'b1, 1'b0, a, d};
        cyc;
        reg_req = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cyc;
        reg_req = '{1'b0, 1'b1, a, 8'h00};
        cyc;
        reg_req = '0;
        chk({reg_rvalid, 7'h00}, 8'h80);
        chk(reg_rdata, e);
    endtask
    task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic f);
        cyc;
        sample = '{x, y, 16'h0000};
        sample_valid = 1'b1;
        cyc;
        sample_valid = 1'b0;
        chk({7'h00, quiet_flag}, {7'h00, f});
    endtask
    // Packs flag, host levels and both pins into one byte
    task automatic pins(input logic [7:0] e);
        cyc;
        chk({1'b0, quiet_flag, level_b, level_a, irq_out_a_oe, irq_out_a_o,
            irq_out_b_oe, irq_out_b_o}, e);
    endtask
    task automatic t_regs;
        logic [7:0] ofs [7] = '{8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h5d, 8'h5e};
        pins(8'h00);
        foreach (ofs[i]) begin
            rd(ofs[i], RST_BYTE);
            wr(ofs[i], 8'ha5);
            rd(ofs[i], 8'ha5);
            wr(ofs[i], RST_BYTE);
        end
        wr(8'h00, 8'hff);
        rd(8'h00, RD_UNMAPPED);
        pins(8'h00);
    endtask
    task automatic t_fall;
        wr(OFS_QUIET_CTL, 8'h00);
        wr(OFS_AXIS_EN, 8'h07);
        wr(OFS_LEVEL_HI, 8'h00);
        wr(OFS_LEVEL_LO, 8'h22);
        wr(OFS_TIME_LO, 8'h03);
        wr(OFS_MAP_B, 8'h40);
        wr(OFS_QUIET_CTL, 8'h04);
        measure_mode = 1'b1;
        repeat (3) smp(16'hffdf, 16'h0021, 1'b0);
        for (int i = 0; i < 20 && settled !== 1'b1; i++) cyc;
        chk({7'h00, settled}, 8'h01);
        smp(16'hffdf, 16'h0000, 1'b0);
        smp(16'h0000, 16'hffde, 1'b0);
        smp(16'h0021, 16'h0000, 1'b0);
        smp(16'h0000, 16'hffdf, 1'b0);
        smp(16'h0000, 16'h0000, 1'b1);
        pins(8'h63);
    endtask
    task automatic t_pins;
        wr(OFS_PIN_B_CFG, 8'h80);
        pins(8'h42);
        wr(OFS_MAP_A, 8'h41);
        pins(8'h5e);
        other_events = 8'h01;
        rd(OFS_STATUS, 8'h41);
        pins(8'h3f);
        other_events = 8'h00;
        cyc;
        pins(8'h2b);
        wr(OFS_MAP_B, 8'h00);
        pins(8'h29);
        wr(OFS_PIN_B_CFG, 8'h00);
        pins(8'h29);
        wr(OFS_TIME_LO, 8'h01);
        smp(16'h0000, 16'h7fff, 1'b0);
        wr(OFS_AXIS_EN, 8'h05);
        smp(16'h0000, 16'h7fff, 1'b1);
    endtask
    initial begin
        rst_n = 1'b0;
        reg_req = '0;
        measure_mode = 1'b0;
        sample_valid = 1'b0;
        sample = '0;
        other_events = 8'h00;
        repeat (8) cyc;
        rst_n = 1'b1;
        t_regs;
        t_fall;
        t_pins;
        end_sim;
    end
    // Whole run is about 130 cycles; this limit is far beyond it
    initial begin
        #20000;
        n_errors++;
        end_sim;
    end
endmodule
